/* File: hdl/perf2_defines.svh */
`ifndef PERF2_DEFINES_SVH
`define PERF2_DEFINES_SVH

// ----------------------------------------
// Special register numbers
// ----------------------------------------
`define SPR_MONITOR_CONTROL0 10'h3B8
`define SPR_SECOND_COUNTER 10'h3BA
`define SPR_SAMPLED_INSTR 10'h3BB
`define SPR_SAMPLED_OPERAND 10'h3BF

// ----------------------------------------
// Control register fields (little-endian positions)
// ----------------------------------------
`define MC0_SEL_MSB 5
`define MC0_SEL_LSB 0
`define MC0_INTERRUPT_SIGNAL_ENABLE_BIT 26

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MC0_RESET 32'h0000_0000
`define COUNTER_RESET 32'h0000_0000
`define SAMPLE_RESET 32'h0000_0000

// ----------------------------------------
// Time-base lower bit positions for selector 0..3
// ----------------------------------------
`define TB_SEL0_BIT 16
`define TB_SEL1_BIT 12
`define TB_SEL2_BIT 8
`define TB_SEL3_BIT 0

// ----------------------------------------
// Counts
// ----------------------------------------
`define MAX_PER_CYCLE 3'h4
`define LAST_DEFINED_CODE 6'h14

`endif

/* File: hdl/perf2_pkg.sv */
package perf2_pkg;

    typedef enum logic [5:0] {
        EV_HOLD = 6'h00,
        EV_CYCLES = 6'h01,
        EV_COMPLETED = 6'h02,
        EV_TB_TRANSITION = 6'h03,
        EV_DISPATCHED = 6'h04,
        EV_LOAD_MISS_CYCLES = 6'h05,
        EV_DCACHE_FILL = 6'h06,
        EV_ITLB_MISS = 6'h07,
        EV_BRANCH_COMPLETED = 6'h08,
        EV_RESERVATION = 6'h09,
        EV_MFSPR_DISPATCH = 6'h0A,
        EV_ICBI = 6'h0B,
        EV_PIPE_FLUSH = 6'h0C,
        EV_BRANCH_RESULT = 6'h0D,
        EV_SIMPLE0_RESULT = 6'h0E,
        EV_COMPLEX_RESULT = 6'h0F,
        EV_BRANCH_DISPATCH = 6'h10,
        EV_SIMPLE0_DISPATCH = 6'h11,
        EV_LOADS_COMPLETED = 6'h12,
        EV_COMPLEX_DISPATCH = 6'h13,
        EV_SNOOP_HIT = 6'h14
    } event_sel_type;

endpackage : perf2_pkg

/* File: hdl/sample_reg.sv */
`timescale 1ns/10ps
`include "perf2_defines.svh"

module sample_reg (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Hardware capture
    input wire logic capture,
    input wire logic [31:0] capture_value,
    // Software write
    input wire logic wr,
    input wire logic [31:0] wdata,
    // Held value
    output logic [31:0] value_q
);

    // Capture beats a software write landing in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            value_q <= `SAMPLE_RESET;
        end else if (capture) begin
            value_q <= capture_value;
        end else if (wr) begin
            value_q <= wdata;
        end
    end

endmodule : sample_reg

/* File: hdl/event_decode.sv */
`timescale 1ns/10ps
`include "perf2_defines.svh"

module event_decode (
    // Selection
    input perf2_pkg::event_sel_type sel,
    // Multi-count events
    input wire logic [2:0] completed_count,
    input wire logic [2:0] dispatched_count,
    input wire logic [2:0] loads_completed,
    input wire logic [1:0] branch_complete,
    // Single events
    input wire logic tb_transition,
    input wire logic load_miss_busy,
    input wire logic dcache_fill,
    input wire logic itlb_miss,
    input wire logic reservation_ok,
    input wire logic mfspr_dispatch,
    input wire logic icbi_event,
    input wire logic pipeline_flush,
    input wire logic branch_result,
    input wire logic simple_integer_unit0_result,
    input wire logic complex_integer_unit_result,
    input wire logic branch_dispatch,
    input wire logic simple_integer_unit0_dispatch,
    input wire logic complex_integer_unit_dispatch,
    input wire logic snoop_hit,
    // Amount to add this cycle
    output logic [2:0] increment
);
    import perf2_pkg::*;

    // Out-of-range counts saturate rather than over-count
    function automatic logic [2:0] clamp(input logic [2:0] n);
        clamp = (n > `MAX_PER_CYCLE) ? `MAX_PER_CYCLE : n;
    endfunction : clamp

    always_comb begin
        unique case (sel)
            EV_HOLD: increment = 3'h0;
            EV_CYCLES: increment = 3'h1;
            EV_COMPLETED: increment = clamp(completed_count);
            EV_TB_TRANSITION: increment = {2'h0, tb_transition};
            EV_DISPATCHED: increment = clamp(dispatched_count);
            EV_LOAD_MISS_CYCLES: increment = {2'h0, load_miss_busy};
            EV_DCACHE_FILL: increment = {2'h0, dcache_fill};
            EV_ITLB_MISS: increment = {2'h0, itlb_miss};
            EV_BRANCH_COMPLETED: increment = branch_complete[1] ? (branch_complete[0] ? 3'h2 : 3'h1) : 3'h0;
            EV_RESERVATION: increment = {2'h0, reservation_ok};
            EV_MFSPR_DISPATCH: increment = {2'h0, mfspr_dispatch};
            EV_ICBI: increment = {2'h0, icbi_event};
            EV_PIPE_FLUSH: increment = {2'h0, pipeline_flush};
            EV_BRANCH_RESULT: increment = {2'h0, branch_result};
            EV_SIMPLE0_RESULT: increment = {2'h0, simple_integer_unit0_result};
            EV_COMPLEX_RESULT: increment = {2'h0, complex_integer_unit_result};
            EV_BRANCH_DISPATCH: increment = {2'h0, branch_dispatch};
            EV_SIMPLE0_DISPATCH: increment = {2'h0, simple_integer_unit0_dispatch};
            EV_LOADS_COMPLETED: increment = clamp(loads_completed);
            EV_COMPLEX_DISPATCH: increment = {2'h0, complex_integer_unit_dispatch};
            EV_SNOOP_HIT: increment = {2'h0, snoop_hit};
            default: increment = 3'h0;
        endcase
    end

endmodule : event_decode

/* File: hdl/perf_counter2_event_sampling.sv */
`timescale 1ns/10ps
`include "perf2_defines.svh"

// Summary of operation
// - Event for second counter chosen by 6-bit control field, bits 0 to 5.
// - Code 0 holds; code 1 counts cycles; code 4 counts dispatched instructions.
// - Code 2 adds zero to four completed instructions per cycle.
// - Code 3 counts transitions of time-base bit 47, 51, 55 or 63.
// - Code 8 adds branches completed: 00 none, 10 one, 11 two, 01 illegal.
// - Code 5 counts every cycle a load miss is serviced.
// - Code 6 counts data cache fills; code 7 counts instruction translation misses.
// - Codes 9, A, B count reservations, speculative mfspr dispatches, icbi instructions.
// - Code C counts pipeline-flushing operations.
// - Codes D, E, F count branch, simple integer, complex unit results.
// - Codes 10, 11, 13 count dispatches to branch, simple, complex units.
// - Code 12 adds zero to four completed loads per cycle.
// - Code 14 counts snoop hits.
// - Threshold interrupt captures address of the instruction that went negative.
// - Other interrupt causes capture last completed instruction address.
// - Threshold interrupt captures that instruction's operand address.
// - Other causes capture a nearby operand address, unrelated to instruction.
// - Sample registers are supervisor-only, at special registers 955 and 959.
// - Samples kept after signalling; interrupt waits for external interrupt enable.
// - Signalling clears interrupt signal enable; software must set it again.

module perf_counter2_event_sampling (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Special register port
    input wire logic [9:0] spr_num,
    input wire logic spr_rd,
    input wire logic spr_wr,
    input wire logic [31:0] spr_wdata,
    input wire logic supervisor_mode,
    output logic [31:0] spr_rdata_q,
    output logic spr_ack_q,
    output logic spr_fault_q,
    // Monitor controls from the rest of the monitor
    input wire logic counting_allowed,
    input wire logic [1:0] timebase_bit_selector,
    input wire logic [31:0] tb_lower,
    // Pipeline events
    input wire logic [2:0] completed_count,
    input wire logic [2:0] dispatched_count,
    input wire logic [2:0] loads_completed,
    input wire logic [1:0] branch_complete,
    input wire logic load_miss_busy,
    input wire logic dcache_fill,
    input wire logic itlb_miss,
    input wire logic reservation_ok,
    input wire logic mfspr_dispatch,
    input wire logic icbi_event,
    input wire logic pipeline_flush,
    input wire logic branch_result,
    input wire logic simple_integer_unit0_result,
    input wire logic complex_integer_unit_result,
    input wire logic branch_dispatch,
    input wire logic simple_integer_unit0_dispatch,
    input wire logic complex_integer_unit_dispatch,
    input wire logic snoop_hit,
    // Interrupt causes and sample sources
    input wire logic threshold_event,
    input wire logic other_pmi_cause,
    input wire logic [31:0] threshold_instr_addr,
    input wire logic [31:0] threshold_operand_addr,
    input wire logic [31:0] last_completed_addr,
    input wire logic [31:0] recent_operand_addr,
    input wire logic external_interrupt_enable,
    // Status out
    output perf2_pkg::event_sel_type event_select_q,
    output logic interrupt_signal_enable_q,
    output logic counter_negative_q,
    output logic perf_monitor_interrupt_q,
    output logic interrupt_taken_q,
    output logic [31:0] second_event_counter_q,
    output logic [31:0] sampled_instruction_address_q,
    output logic [31:0] sampled_operand_address_q
);
    import perf2_pkg::*;

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    logic hit_ctl;
    logic hit_cnt;
    logic hit_sia;
    logic hit_sda;
    logic hit_any;
    logic wr_ctl;
    logic wr_cnt;
    logic wr_sia;
    logic wr_sda;

    assign hit_ctl = (spr_num == `SPR_MONITOR_CONTROL0);
    assign hit_cnt = (spr_num == `SPR_SECOND_COUNTER);
    assign hit_sia = (spr_num == `SPR_SAMPLED_INSTR);
    assign hit_sda = (spr_num == `SPR_SAMPLED_OPERAND);
    assign hit_any = hit_ctl | hit_cnt | hit_sia | hit_sda;
    assign wr_ctl = spr_wr & supervisor_mode & hit_ctl;
    assign wr_cnt = spr_wr & supervisor_mode & hit_cnt;
    assign wr_sia = spr_wr & supervisor_mode & hit_sia;
    assign wr_sda = spr_wr & supervisor_mode & hit_sda;

    // ----------------------------------------
    // Interrupt signalling
    // ----------------------------------------
    logic pmi_signal;
    logic take_now;

    assign pmi_signal = interrupt_signal_enable_q & (threshold_event | other_pmi_cause);
    assign take_now = perf_monitor_interrupt_q & external_interrupt_enable;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            event_select_q <= event_sel_type'(6'(`MC0_RESET >> `MC0_SEL_LSB));
        end else if (wr_ctl) begin
            event_select_q <= event_sel_type'(spr_wdata[`MC0_SEL_MSB:`MC0_SEL_LSB]);
        end
    end

    // hardware clear beats a software set, so a signal never re-arms itself
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            interrupt_signal_enable_q <= 1'(`MC0_RESET >> `MC0_INTERRUPT_SIGNAL_ENABLE_BIT);
        end else if (pmi_signal) begin
            interrupt_signal_enable_q <= 1'b0;
        end else if (wr_ctl) begin
            interrupt_signal_enable_q <= spr_wdata[`MC0_INTERRUPT_SIGNAL_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            perf_monitor_interrupt_q <= 1'b0;
        end else if (pmi_signal) begin
            perf_monitor_interrupt_q <= 1'b1;
        end else if (take_now) begin
            perf_monitor_interrupt_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            interrupt_taken_q <= 1'b0;
        end else begin
            interrupt_taken_q <= take_now;
        end
    end

    // ----------------------------------------
    // Event selection and counting
    // ----------------------------------------
    logic tb_bit;
    logic tb_prev_q;
    logic [2:0] increment;

    always_comb begin
        unique case (timebase_bit_selector)
            2'h0: tb_bit = tb_lower[`TB_SEL0_BIT];
            2'h1: tb_bit = tb_lower[`TB_SEL1_BIT];
            2'h2: tb_bit = tb_lower[`TB_SEL2_BIT];
            2'h3: tb_bit = tb_lower[`TB_SEL3_BIT];
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tb_prev_q <= 1'b0;
        end else begin
            tb_prev_q <= tb_bit;
        end
    end

    event_decode u_decode (
        .sel(event_select_q),
        .completed_count(completed_count),
        .dispatched_count(dispatched_count),
        .loads_completed(loads_completed),
        .branch_complete(branch_complete),
        .tb_transition(tb_bit ^ tb_prev_q),
        .load_miss_busy(load_miss_busy),
        .dcache_fill(dcache_fill),
        .itlb_miss(itlb_miss),
        .reservation_ok(reservation_ok),
        .mfspr_dispatch(mfspr_dispatch),
        .icbi_event(icbi_event),
        .pipeline_flush(pipeline_flush),
        .branch_result(branch_result),
        .simple_integer_unit0_result(simple_integer_unit0_result),
        .complex_integer_unit_result(complex_integer_unit_result),
        .branch_dispatch(branch_dispatch),
        .simple_integer_unit0_dispatch(simple_integer_unit0_dispatch),
        .complex_integer_unit_dispatch(complex_integer_unit_dispatch),
        .snoop_hit(snoop_hit),
        .increment(increment)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            second_event_counter_q <= `COUNTER_RESET;
            counter_negative_q <= 1'b0;
        end else if (wr_cnt) begin
            second_event_counter_q <= spr_wdata;
            counter_negative_q <= spr_wdata[31];
        end else if (counting_allowed) begin
            second_event_counter_q <= second_event_counter_q + {29'h0, increment};
            counter_negative_q <= (second_event_counter_q + {29'h0, increment}) >> 31 != 32'h0;
        end
    end

    // ----------------------------------------
    // Sampled addresses
    // ----------------------------------------
    logic [31:0] sia_src;
    logic [31:0] sda_src;

    assign sia_src = threshold_event ? threshold_instr_addr : last_completed_addr;
    assign sda_src = threshold_event ? threshold_operand_addr : recent_operand_addr;

    sample_reg u_sia (
        .clk(clk),
        .nrst(nrst),
        .capture(pmi_signal),
        .capture_value(sia_src),
        .wr(wr_sia),
        .wdata(spr_wdata),
        .value_q(sampled_instruction_address_q)
    );

    sample_reg u_sda (
        .clk(clk),
        .nrst(nrst),
        .capture(pmi_signal),
        .capture_value(sda_src),
        .wr(wr_sda),
        .wdata(spr_wdata),
        .value_q(sampled_operand_address_q)
    );

    // ----------------------------------------
    // Register read-back
    // ----------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctl) begin
            rd_mux[`MC0_SEL_MSB:`MC0_SEL_LSB] = event_select_q;
            rd_mux[`MC0_INTERRUPT_SIGNAL_ENABLE_BIT] = interrupt_signal_enable_q;
        end else if (hit_cnt) begin
            rd_mux = second_event_counter_q;
        end else if (hit_sia) begin
            rd_mux = sampled_instruction_address_q;
        end else if (hit_sda) begin
            rd_mux = sampled_operand_address_q;
        end
    end

    // user-mode access faults and reads zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            spr_rdata_q <= 32'h0000_0000;
            spr_ack_q <= 1'b0;
            spr_fault_q <= 1'b0;
        end else begin
            spr_rdata_q <= (spr_rd & supervisor_mode) ? rd_mux : 32'h0000_0000;
            spr_ack_q <= (spr_rd | spr_wr) & hit_any;
            spr_fault_q <= (spr_rd | spr_wr) & hit_any & ~supervisor_mode;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_counting;
        counting_allowed && !wr_cnt;
    endsequence
    sequence s_signalled;
        pmi_signal && !wr_ctl;
    endsequence
    sequence s_waiting;
        perf_monitor_interrupt_q && !external_interrupt_enable && !pmi_signal;
    endsequence

    property p_hold;
        s_counting and (event_select_q == EV_HOLD) |=> $stable(second_event_counter_q);
    endproperty
    a_hold: assert property (p_hold) else $error("hold code changed counter");

    property p_cycles;
        s_counting and (event_select_q == EV_CYCLES) |=> second_event_counter_q == $past(second_event_counter_q) + 32'h1;
    endproperty
    a_cycles: assert property (p_cycles) else $error("cycle code did not add one");

    property p_completed;
        s_counting and (event_select_q == EV_COMPLETED) |=>
            second_event_counter_q - $past(second_event_counter_q) <= 32'h4;
    endproperty
    a_completed: assert property (p_completed) else $error("completed count above four");

    property p_tb;
        s_counting and (event_select_q == EV_TB_TRANSITION) and (tb_bit != tb_prev_q) |=>
            second_event_counter_q == $past(second_event_counter_q) + 32'h1;
    endproperty
    a_tb: assert property (p_tb) else $error("time-base transition missed");

    property p_branch_illegal;
        s_counting and (event_select_q == EV_BRANCH_COMPLETED) and (branch_complete == 2'h1) |=>
            $stable(second_event_counter_q);
    endproperty
    a_branch_illegal: assert property (p_branch_illegal) else $error("illegal branch code counted");

    property p_undefined;
        s_counting and (event_select_q > `LAST_DEFINED_CODE) |=> $stable(second_event_counter_q);
    endproperty
    a_undefined: assert property (p_undefined) else $error("undefined code changed counter");

    property p_sia_thresh;
        pmi_signal && threshold_event |=> sampled_instruction_address_q == $past(threshold_instr_addr);
    endproperty
    a_sia_thresh: assert property (p_sia_thresh) else $error("threshold instruction not sampled");

    property p_sia_other;
        pmi_signal && !threshold_event |=> sampled_instruction_address_q == $past(last_completed_addr);
    endproperty
    a_sia_other: assert property (p_sia_other) else $error("last completed address not sampled");

    property p_sda_thresh;
        pmi_signal && threshold_event |=> sampled_operand_address_q == $past(threshold_operand_addr);
    endproperty
    a_sda_thresh: assert property (p_sda_thresh) else $error("threshold operand not sampled");

    property p_disarm;
        s_signalled |=> !interrupt_signal_enable_q ##1
            (interrupt_signal_enable_q == ($past(wr_ctl) && $past(spr_wdata[`MC0_INTERRUPT_SIGNAL_ENABLE_BIT])));
    endproperty
    a_disarm: assert property (p_disarm) else $error("signal enable not cleared");

    property p_keep;
        s_waiting ##1 (!wr_sia && !pmi_signal) |=> $stable(sampled_instruction_address_q);
    endproperty
    a_keep: assert property (p_keep) else $error("sample lost while pending");

    property p_take;
        s_waiting ##1 external_interrupt_enable |=> interrupt_taken_q;
    endproperty
    a_take: assert property (p_take) else $error("pending interrupt not taken");

    property p_priv;
        spr_wr && hit_sia && !supervisor_mode && !pmi_signal |=> $stable(sampled_instruction_address_q) && spr_fault_q;
    endproperty
    a_priv: assert property (p_priv) else $error("user write reached sample register");

endmodule : perf_counter2_event_sampling

/* File: dv/pipe_model.sv */
`timescale 1ns/10ps

module pipe_model (
    // Stimulus
    input wire logic [31:0] word,
    // Event lines
    output logic [2:0] cc,
    output logic [2:0] dc,
    output logic [2:0] lc,
    output logic [1:0] bc,
    output logic [13:0] sg
);
    assign cc = word[2] ? 3'h4 : word[2:0];
    assign dc = word[5] ? 3'h4 : word[5:3];
    assign lc = word[8] ? 3'h4 : word[8:6];
    assign bc = {word[9], word[9] & word[10]};
    assign sg = word[24:11];
endmodule : pipe_model

/* File: dv/testbench.sv */
`timescale 1ns/10ps

module testbench;
    import perf2_pkg::*;
    logic clk = 0, nrst = 0, rd = 0, wr = 0, sup = 1, allow = 0, thr = 0, oth = 0, ee = 0, prev = 0;
    logic ack, fault, en, pend, taken, neg;
    logic [1:0] tsel = 0, bc;
    logic [2:0] cc, dc, lc;
    logic [5:0] sel_now = 0;
    logic [9:0] num = 0;
    logic [13:0] sg;
    logic [31:0] wd = 0, word = 0, tb = 0, exp_c = 0, a0, rdata, cnt, sampled_instruction_address, sda, rnd = 32'h0000_40af;
    logic [31:0] adr [4] = '{default: 0};
    logic [5:0] codes [14] = '{6'h05, 6'h06, 6'h07, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h0f,
        6'h10, 6'h11, 6'h13, 6'h14};
    logic [4:0] tp [4] = '{5'h10, 5'h0c, 5'h08, 5'h00};
    logic [31:0] cq [$];
    logic [32:0] rq [$];
    int error_cnt = 0, checked = 0;

    pipe_model u_pipe_model (.word(word), .cc(cc), .dc(dc), .lc(lc), .bc(bc), .sg(sg));

    perf_counter2_event_sampling u_perf_counter2_event_sampling (.clk(clk), .nrst(nrst), .spr_num(num),
        .spr_rd(rd), .spr_wr(wr), .spr_wdata(wd), .supervisor_mode(sup), .spr_rdata_q(rdata), .spr_ack_q(ack),
        .spr_fault_q(fault), .counting_allowed(allow), .timebase_bit_selector(tsel), .tb_lower(tb),
        .completed_count(cc), .dispatched_count(dc), .loads_completed(lc), .branch_complete(bc),
        .load_miss_busy(sg[0]), .dcache_fill(sg[1]), .itlb_miss(sg[2]), .reservation_ok(sg[3]),
        .mfspr_dispatch(sg[4]), .icbi_event(sg[5]), .pipeline_flush(sg[6]), .branch_result(sg[7]),
        .simple_integer_unit0_result(sg[8]), .complex_integer_unit_result(sg[9]), .branch_dispatch(sg[10]),
        .simple_integer_unit0_dispatch(sg[11]), .complex_integer_unit_dispatch(sg[12]), .snoop_hit(sg[13]),
        .threshold_event(thr), .other_pmi_cause(oth), .threshold_instr_addr(adr[0]),
        .threshold_operand_addr(adr[1]), .last_completed_addr(adr[2]), .recent_operand_addr(adr[3]),
        .external_interrupt_enable(ee), .event_select_q(), .interrupt_signal_enable_q(en),
        .counter_negative_q(neg), .perf_monitor_interrupt_q(pend), .interrupt_taken_q(taken),
        .second_event_counter_q(cnt), .sampled_instruction_address_q(sampled_instruction_address), .sampled_operand_address_q(sda));

    always #50 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic logic [2:0] inc(input logic [5:0] s, input logic tr);
        inc = 3'h0;
        for (int i = 0; i < 14; i++)
            if (s == codes[i]) inc = {2'h0, sg[i]};
        case (s)
            6'h01: inc = 3'h1;
            6'h02: inc = cc;
            6'h03: inc = {2'h0, tr};
            6'h04: inc = dc;
            6'h08: inc = {1'h0, bc[1] & bc[0], bc[1] & ~bc[0]};
            6'h12: inc = lc;
            default: ;
        endcase
    endfunction : inc

    task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic spr(input logic w, input logic [9:0] n, input logic [31:0] d, input logic [32:0] e);
        if (n inside {10'h3b8, 10'h3ba, 10'h3bb, 10'h3bf}) rq.push_back(e);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        num <= n;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : spr

    task automatic end_sim;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim

    // ----------------------------------------
    // Driver and expected counter
    // ----------------------------------------
    always @(posedge clk) begin
        logic tbit;
        tbit = tb[tp[tsel]];
        if (nrst) begin
            if (allow) exp_c = exp_c + 32'(inc(sel_now, tbit != prev));
            // Software write wins over counting
            if (wr && sup && num == 10'h3ba) exp_c = wd;
            if (wr && sup && num == 10'h3b8) sel_now = wd[5:0];
            cq.push_back(exp_c);
        end
        prev = nrst & tbit;
        rnd = xs(rnd);
        word <= rnd;
        tb <= {rnd[15:0], rnd[31:16]};
        allow <= |rnd[31:30];
    end

    always @(posedge clk) begin
        #1;
        if (cq.size() > 0) chk("counter", {1'b0, cnt}, {1'b0, cq.pop_front()});
        if (nrst) chk("negative", {32'h0, neg}, {32'h0, cnt[31]});
        if (ack && rq.size() > 0) chk("access", {fault, rdata}, rq.pop_front());
    end

    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        spr(1'b0, 10'h3bb, 0, 33'h0);
        spr(1'b0, 10'h3bf, 0, 33'h0);
        // Every defined code, the next two undefined ones, and all four time-base bits
        for (int k = 0; k < 31; k++) begin
            if (k >= 22 && !k[0]) tsel <= k[2:1];
            repeat (2) @(posedge clk);
            spr(1'b1, 10'h3b8, (k < 23) ? 32'(k) : {30'h0, k[0], 1'b1}, 33'h0);
            repeat (20) @(posedge clk);
        end
        spr(1'b1, 10'h3ba, 32'h7fff_fffc, 33'h0);
        $display("test events done");
        spr(1'b1, 10'h3b8, 32'h0400_0001, 33'h0);
        adr <= '{rnd, ~rnd, {rnd[15:0], rnd[31:16]}, rnd ^ 32'h0f0f_0f0f};
        thr <= 1'b1;
        @(posedge clk);
        thr <= 1'b0;
        #1 chk("pending", {31'h0, pend, en}, 33'h2);
        a0 = adr[0];
        adr[0] <= ~a0;
        thr <= 1'b1;
        @(posedge clk);
        thr <= 1'b0;
        spr(1'b0, 10'h3bb, 0, {1'b0, a0});
        spr(1'b0, 10'h3bf, 0, {1'b0, adr[1]});
        ee <= 1'b1;
        @(posedge clk);
        #1 chk("taken", {31'h0, pend, taken}, 33'h1);
        spr(1'b1, 10'h3b8, 32'h0400_0001, 33'h0);
        oth <= 1'b1;
        @(posedge clk);
        oth <= 1'b0;
        spr(1'b0, 10'h3bb, 0, {1'b0, adr[2]});
        spr(1'b0, 10'h3bf, 0, {1'b0, adr[3]});
        spr(1'b0, 10'h3b8, 0, 33'h1);
        $display("test interrupt done");
        sup <= 1'b0;
        spr(1'b1, 10'h3bb, 32'h1234_5678, {1'b1, 32'h0});
        spr(1'b0, 10'h3bf, 0, {1'b1, 32'h0});
        sup <= 1'b1;
        spr(1'b0, 10'h3bc, 0, 33'h0);
        spr(1'b0, 10'h3bb, 0, {1'b0, adr[2]});
        spr(1'b1, 10'h3bf, 32'h5a5a_c3c3, 33'h0);
        spr(1'b0, 10'h3bf, 0, {1'b0, 32'h5a5a_c3c3});
        repeat (3) @(posedge clk);
        $display("test access done");
        end_sim();
    end

    initial begin
        #1_000_000;
        error_cnt++;
        end_sim();
    end
endmodule : testbench
